// ---- design/smbt_defs.vh ----
`ifndef SMBT_DEFS_VH
`define SMBT_DEFS_VH
// system clock, 20 MHz
`define SMBT_CLK_HZ 32'h01312D00
// supported serial clock rates in hertz
`define SMBT_RATE_125K 32'h0001E848
`define SMBT_RATE_250K 32'h0003D090
`define SMBT_RATE_500K 32'h0007A120
`define SMBT_RATE_1M 32'h000F4240
`define SMBT_RATE_2M 32'h001E8480
`define SMBT_RATE_4M 32'h003D0900
`define SMBT_RATE_8M 32'h007A1200
// highest legal phase/polarity setting
`define SMBT_MODE_MAX 32'h00000003
// config flag word: bit order field
`define SMBT_CFG_LSB_FIRST 0
// open status codes
`define SMBT_ST_OK 16'h0000
`define SMBT_ST_NO_DRIVER 16'h5200
`define SMBT_ST_ALREADY_OPEN 16'h5207
`define SMBT_ST_NO_RESOURCE 16'h521D
`define SMBT_ST_BAD_RATE 16'h5225
`define SMBT_ST_BAD_MODE 16'h5228
// transfer kinds
`define SMBT_KIND_DUPLEX 2'h0
`define SMBT_KIND_WRITE 2'h1
`define SMBT_KIND_READ 2'h2
// byte driven out during read-only transfers
`define SMBT_FILLER 8'hFF
// receive buffer shape
`define SMBT_FIFO_WIDTH 8
`define SMBT_FIFO_DEPTH 8
`define SMBT_FIFO_AW 3
`endif

// ---- design/smbt_fifo.v ----
`timescale 1ns/10ps
`default_nettype none
module smbt_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // clock and reset
   input wire clk,
   input wire arst_n,
   // fill side
   input wire in_valid,
   input wire [WIDTH-1:0] in_data,
   output wire in_ready,
   // drain side
   output wire out_valid,
   output wire [WIDTH-1:0] out_data,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   // full and empty straight from the occupancy count
   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // storage has no reset; only the pointers and the count need one
   always @(posedge clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   // pointers wrap naturally since depth is a power of two
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
         if (pop)
            rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
         if (push && !pop)
            count <= count + {{AW{1'b0}}, 1'b1};
         else if (pop && !push)
            count <= count - {{AW{1'b0}}, 1'b1};
      end
   end
endmodule
`default_nettype wire

// ---- design/smbt_spi_master.v ----
// Summary of operation
// - open takes phase/polarity setting 0..3, which fixes sample and shift edges.
// - serial clock rate is one of seven rates from 125 kHz to 8 MHz.
// - config bit 0 set sends and receives least significant bit first.
// - bad rate refused with 0x5225, bad phase/polarity setting with 0x5228.
// - open while already open refused with 0x5207; success reports zero.
// - open reports 0x5200 without driver, 0x521D without hardware resource.
// - close on a closed port does nothing and makes no bus activity.
// - full duplex shifts one byte out and one in per eight clocks.
// - full duplex returns as many received bytes as were sent, in order.
// - write-only shifts out all bytes and discards the input line.
// - read-only clocks in exactly the requested byte count and returns them.
// - a transfer ends with one done pulse; no other events exist.
// - master only: drives clock and data out, samples data in.
`timescale 1ns/10ps
`default_nettype none
`include "smbt_defs.vh"
module smbt_spi_master (
   // clock and reset
   input wire clk,
   input wire arst_n,
   // open and close requests
   input wire port_open_request,
   input wire port_close_request,
   input wire [31:0] phase_polarity_select,
   input wire [31:0] serial_clock_rate,
   input wire [31:0] config_flag_word,
   input wire driver_present,
   input wire resource_available,
   // open answer and port state
   output reg open_done,
   output reg [15:0] open_status,
   output reg port_is_open,
   // transfer request
   input wire xfer_start,
   input wire [1:0] xfer_kind,
   input wire [15:0] transmit_byte_count,
   input wire [15:0] read_byte_count,
   output wire busy,
   output reg xfer_done,
   // bytes to transmit
   input wire transmit_bytes_valid,
   input wire [7:0] transmit_bytes_data,
   output wire transmit_bytes_ready,
   // bytes received
   output wire receive_bytes_valid,
   output wire [7:0] receive_bytes_data,
   input wire receive_bytes_ready,
   // serial pins
   output reg sck,
   output reg mosi,
   input wire miso
);
   localparam ST_IDLE = 2'h0;
   localparam ST_LOAD = 2'h1;
   localparam ST_SHIFT = 2'h2;
   localparam ST_DONE = 2'h3;

   // half serial period in system clocks, 4 MHz and 8 MHz rounded down
   localparam [31:0] HALF_125K = `SMBT_CLK_HZ / (2 * `SMBT_RATE_125K);
   localparam [31:0] HALF_250K = `SMBT_CLK_HZ / (2 * `SMBT_RATE_250K);
   localparam [31:0] HALF_500K = `SMBT_CLK_HZ / (2 * `SMBT_RATE_500K);
   localparam [31:0] HALF_1M = `SMBT_CLK_HZ / (2 * `SMBT_RATE_1M);
   localparam [31:0] HALF_2M = `SMBT_CLK_HZ / (2 * `SMBT_RATE_2M);
   localparam [31:0] HALF_4M = `SMBT_CLK_HZ / (2 * `SMBT_RATE_4M);
   localparam [31:0] HALF_8M = `SMBT_CLK_HZ / (2 * `SMBT_RATE_8M);

   reg [1:0] state;
   reg [1:0] kind;
   reg cpol;
   reg cpha;
   reg lsb_first;
   reg [7:0] half;
   reg [7:0] div_cnt;
   reg [3:0] edge_idx;
   reg [15:0] bytes_left;
   reg [7:0] tx_sr;
   reg [7:0] rx_sr;
   reg miso_meta;
   reg miso_sync;
   reg rx_push;
   reg [7:0] rx_byte;
   reg [7:0] next_half;
   reg rate_ok;
   reg cap_d1;
   reg cap_d2;
   reg last_d1;
   reg last_d2;
   wire fifo_room;
   wire need_tx;
   wire need_rx;
   wire byte_ok;
   wire leading;
   wire sample_edge;
   wire shift_edge;
   wire [7:0] next_rx;
   wire [7:0] load_byte;
   wire [15:0] req_count;
   wire sample_now;
   wire last_bit;
   wire rx_wait;

   // pin input crosses into the clk domain through two flops
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         miso_meta <= 1'b0;
         miso_sync <= 1'b0;
      end
      else
      begin
         miso_meta <= miso;
         miso_sync <= miso_meta;
      end
   end

   // rate decode; any other value is unsupported
   always @*
   begin
      rate_ok = 1'b1;
      next_half = HALF_1M[7:0];
      case (serial_clock_rate)
         `SMBT_RATE_125K: next_half = HALF_125K[7:0];
         `SMBT_RATE_250K: next_half = HALF_250K[7:0];
         `SMBT_RATE_500K: next_half = HALF_500K[7:0];
         `SMBT_RATE_1M: next_half = HALF_1M[7:0];
         `SMBT_RATE_2M: next_half = HALF_2M[7:0];
         `SMBT_RATE_4M: next_half = HALF_4M[7:0];
         `SMBT_RATE_8M: next_half = HALF_8M[7:0];
         default: rate_ok = 1'b0;
      endcase
   end

   // open and close; the port setup is frozen while a transfer runs
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         port_is_open <= 1'b0;
         open_done <= 1'b0;
         open_status <= `SMBT_ST_OK;
         cpol <= 1'b0;
         cpha <= 1'b0;
         lsb_first <= 1'b0;
         half <= HALF_1M[7:0];
      end
      else
      begin
         open_done <= 1'b0;
         if (port_open_request)
         begin
            open_done <= 1'b1;
            if (port_is_open)
               open_status <= `SMBT_ST_ALREADY_OPEN;
            else if (!driver_present)
               open_status <= `SMBT_ST_NO_DRIVER;
            else if (!resource_available)
               open_status <= `SMBT_ST_NO_RESOURCE;
            else if (phase_polarity_select > `SMBT_MODE_MAX)
               open_status <= `SMBT_ST_BAD_MODE;
            else if (!rate_ok)
               open_status <= `SMBT_ST_BAD_RATE;
            else
            begin
               open_status <= `SMBT_ST_OK;
               port_is_open <= 1'b1;
               cpol <= phase_polarity_select[1];
               cpha <= phase_polarity_select[0];
               // upper flag bits are reserved and not looked at
               lsb_first <= config_flag_word[`SMBT_CFG_LSB_FIRST];
               half <= next_half;
            end
         end
         else if (port_close_request && state == ST_IDLE)
            port_is_open <= 1'b0;
      end
   end

   // which streams the current kind uses
   assign need_tx = (kind != `SMBT_KIND_READ);
   assign need_rx = (kind != `SMBT_KIND_WRITE);
   // a byte only starts once its data and its buffer slot exist;
   // the slot count is only trusted once the previous byte has landed
   assign byte_ok = (!need_tx || transmit_bytes_valid) && (!need_rx || fifo_room)
      && !rx_wait;
   assign transmit_bytes_ready = (state == ST_LOAD) && need_tx && byte_ok;
   assign load_byte = need_tx ? transmit_bytes_data : `SMBT_FILLER;
   assign busy = (state != ST_IDLE);
   assign req_count = (xfer_kind == `SMBT_KIND_READ) ? read_byte_count : transmit_byte_count;

   // even edges lead away from idle level, odd ones return
   assign leading = ~edge_idx[0];
   assign sample_edge = leading ^ cpha;
   // with second-edge sampling the first bit is already on the line
   assign shift_edge = ~sample_edge & ~(cpha & (edge_idx == 4'h0));
   assign next_rx = lsb_first ? {miso_sync, rx_sr[7:1]} : {rx_sr[6:0], miso_sync};
   // a sample edge is due when the divider runs out in the shift state
   assign sample_now = (state == ST_SHIFT) && (div_cnt == 8'h00) && sample_edge;
   // edges 14 and 15 close a byte; only one of them samples
   assign last_bit = (edge_idx[3:1] == 3'h7);
   // a byte still on its way into the buffer holds back the next one
   assign rx_wait = cap_d1 | cap_d2 | rx_push;

   // byte engine; sck rests at the idle level between bytes
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= ST_IDLE;
         kind <= `SMBT_KIND_DUPLEX;
         bytes_left <= 16'h0000;
         div_cnt <= 8'h00;
         edge_idx <= 4'h0;
         tx_sr <= 8'h00;
         sck <= 1'b0;
         mosi <= 1'b1;
         xfer_done <= 1'b0;
      end
      else
      begin
         xfer_done <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               sck <= cpol;
               edge_idx <= 4'h0;
               // requests on a closed port are ignored
               if (xfer_start && port_is_open && !port_open_request)
               begin
                  kind <= xfer_kind;
                  bytes_left <= req_count;
                  if (req_count == 16'h0000)
                     state <= ST_DONE;
                  else
                     state <= ST_LOAD;
               end
            end
            ST_LOAD:
            begin
               if (byte_ok)
               begin
                  tx_sr <= load_byte;
                  mosi <= lsb_first ? load_byte[0] : load_byte[7];
                  div_cnt <= half - 8'h01;
                  edge_idx <= 4'h0;
                  state <= ST_SHIFT;
               end
            end
            ST_SHIFT:
            begin
               if (div_cnt != 8'h00)
                  div_cnt <= div_cnt - 8'h01;
               else
               begin
                  div_cnt <= half - 8'h01;
                  sck <= ~sck;
                  edge_idx <= edge_idx + 4'h1;
                  // the bit on the line is taken later by the capture pipeline
                  if (shift_edge)
                  begin
                     // next bit onto the line, old one out of the way
                     tx_sr <= lsb_first ? {1'b1, tx_sr[7:1]} : {tx_sr[6:0], 1'b1};
                     mosi <= lsb_first ? tx_sr[1] : tx_sr[6];
                  end
                  // sixteen edges make eight clocks, one byte
                  if (edge_idx == 4'hF)
                  begin
                     bytes_left <= bytes_left - 16'h0001;
                     if (bytes_left == 16'h0001)
                        state <= ST_DONE;
                     else
                        state <= ST_LOAD;
                  end
               end
            end
            ST_DONE:
            begin
               // the answer waits until the last byte sits in the buffer
               if (!rx_wait)
               begin
                  xfer_done <= 1'b1;
                  mosi <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // miso arrives two clocks behind the pin, so each bit is taken two clocks
   // after its sample edge; on the edge itself the fastest rate sees a stale bit
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cap_d1 <= 1'b0;
         cap_d2 <= 1'b0;
         last_d1 <= 1'b0;
         last_d2 <= 1'b0;
         rx_sr <= 8'h00;
         rx_byte <= 8'h00;
         rx_push <= 1'b0;
      end
      else
      begin
         cap_d1 <= sample_now;
         cap_d2 <= cap_d1;
         last_d1 <= sample_now && last_bit;
         last_d2 <= last_d1;
         rx_push <= 1'b0;
         // each stage is a one-clock pulse, sample edges are at least two apart
         if (cap_d2)
            rx_sr <= next_rx;
         if (last_d2)
         begin
            rx_byte <= next_rx;
            rx_push <= need_rx;
         end
      end
   end

   // received bytes wait here; a stalled reader pauses the engine
   smbt_fifo #(
      .WIDTH(`SMBT_FIFO_WIDTH),
      .DEPTH(`SMBT_FIFO_DEPTH),
      .AW(`SMBT_FIFO_AW)
   ) u_rx_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .in_valid(rx_push),
      .in_data(rx_byte),
      .in_ready(fifo_room),
      .out_valid(receive_bytes_valid),
      .out_data(receive_bytes_data),
      .out_ready(receive_bytes_ready)
   );
endmodule
`default_nettype wire

// ---- dv/smbt_spi_master_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module smbt_spi_master_assertions (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // open and close
   input wire logic port_open_request,
   input wire logic port_close_request,
   input wire logic [31:0] phase_polarity_select,
   input wire logic driver_present,
   input wire logic resource_available,
   input wire logic open_done,
   input wire logic [15:0] open_status,
   input wire logic port_is_open,
   // transfer
   input wire logic xfer_start,
   input wire logic busy,
   input wire logic xfer_done,
   input wire logic sck
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   a_open_answer: assert property (port_open_request |=> open_done)
      else $error("open request got no answer");
   a_open_cause: assert property (open_done |-> $past(port_open_request))
      else $error("open answer without request");
   a_already_open: assert property (port_open_request && port_is_open
      |=> open_status == 16'h5207 && port_is_open)
      else $error("second open not refused");
   a_no_driver: assert property (port_open_request && !port_is_open && !driver_present
      |=> open_status == 16'h5200 && !port_is_open)
      else $error("missing driver not reported");
   a_bad_mode: assert property (port_open_request && !port_is_open && driver_present
      && resource_available && phase_polarity_select > 32'h3
      |=> open_status == 16'h5228 && !port_is_open)
      else $error("bad phase setting not refused");
   // no clock edges while idle; a new idle level settles one clock after an open
   a_idle_clock: assert property (!busy && !port_open_request && !port_close_request
      && !$past(port_open_request) |=> $stable(sck))
      else $error("serial clock moved while idle");
   a_done_pulse: assert property (xfer_done |=> !xfer_done && !busy)
      else $error("done pulse too long or busy stuck");
   a_start_busy: assert property (xfer_start && port_is_open && !busy
      && !port_open_request |=> busy)
      else $error("transfer start not taken");
endmodule
bind smbt_spi_master smbt_spi_master_assertions u_check (.clk(clk), .arst_n(arst_n),
   .port_open_request(port_open_request), .port_close_request(port_close_request),
   .phase_polarity_select(phase_polarity_select), .driver_present(driver_present),
   .resource_available(resource_available), .open_done(open_done),
   .open_status(open_status), .port_is_open(port_is_open), .xfer_start(xfer_start),
   .busy(busy), .xfer_done(xfer_done), .sck(sck));
`default_nettype wire

// ---- dv/smbt_spi_slave.sv ----
`timescale 1ns/10ps
`default_nettype none
module smbt_spi_slave (
   // serial pins
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   // select and settings
   input wire logic sel,
   input wire logic [1:0] mode,
   input wire logic lsb,
   output logic [7:0] got
);
   logic [2:0] k = 3'h0;
   logic [7:0] rep = 8'hA5;
   logic b;
   // sample on the edge the mode names, next bit shows right after
   always @(sck)
   begin
      if (sel && (sck ^ mode[1] ^ mode[0]))
      begin
         got <= lsb ? {mosi, got[7:1]} : {got[6:0], mosi};
         k <= k + 3'h1;
         rep <= (k == 3'h7) ? rep + 8'h01 : rep;
      end
   end
   assign b = lsb ? rep[k] : rep[3'h7 - k];
   // deselected line shows the inverse so a stale bit never passes
   assign miso = sel ? b : ~b;
endmodule
`default_nettype wire

// ---- dv/smbt_spi_master_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "smbt_defs.vh"
module smbt_spi_master_bench;
   typedef struct {logic [31:0] m, r; logic [2:0] fds; logic [15:0] st;} smbt_row_t;
   // mode, rate, {lsb first, driver, resource}, expected status
   smbt_row_t rows [11] = '{'{32'h0, `SMBT_RATE_1M, 3'h3, 16'h0},
      '{32'h1, `SMBT_RATE_2M, 3'h3, 16'h0}, '{32'h2, `SMBT_RATE_500K, 3'h7, 16'h0},
      '{32'h3, `SMBT_RATE_250K, 3'h3, 16'h0}, '{32'h0, `SMBT_RATE_125K, 3'h7, 16'h0},
      '{32'h1, `SMBT_RATE_4M, 3'h3, 16'h0}, '{32'h3, `SMBT_RATE_8M, 3'h7, 16'h0},
      '{32'h4, `SMBT_RATE_1M, 3'h3, `SMBT_ST_BAD_MODE},
      '{32'h0, 32'h000493E0, 3'h3, `SMBT_ST_BAD_RATE},
      '{32'h0, `SMBT_RATE_1M, 3'h1, `SMBT_ST_NO_DRIVER},
      '{32'h0, `SMBT_RATE_1M, 3'h2, `SMBT_ST_NO_RESOURCE}};
   logic clk = 1'b0, arst_n = 1'b0, oreq = 1'b0, creq = 1'b0, drv = 1'b1, res = 1'b1;
   logic start = 1'b0, tvalid = 1'b0, rx_rdy = 1'b1, sel = 1'b0;
   logic [31:0] mode = 32'h0, rate = 32'h0, cfg = 32'h0;
   logic [1:0] kind = 2'h0;
   logic [15:0] tcnt = 16'h0, rcnt = 16'h0;
   logic [7:0] tdata = 8'h00, exp_rep = 8'hA5;
   logic [7:0] tx [10];
   wire odone, is_open, busy, xdone, tready, rvalid, sck, mosi, miso;
   wire [15:0] ostat;
   wire [7:0] rdata, got;
   int fails = 0, n_checks = 0;
   always #25 clk = ~clk;
   smbt_spi_master DUT (.clk(clk), .arst_n(arst_n), .port_open_request(oreq),
      .port_close_request(creq), .phase_polarity_select(mode), .serial_clock_rate(rate),
      .config_flag_word(cfg), .driver_present(drv), .resource_available(res),
      .open_done(odone), .open_status(ostat), .port_is_open(is_open), .xfer_start(start),
      .xfer_kind(kind), .transmit_byte_count(tcnt), .read_byte_count(rcnt), .busy(busy),
      .xfer_done(xdone), .transmit_bytes_valid(tvalid), .transmit_bytes_data(tdata),
      .transmit_bytes_ready(tready), .receive_bytes_valid(rvalid),
      .receive_bytes_data(rdata), .receive_bytes_ready(rx_rdy), .sck(sck), .mosi(mosi),
      .miso(miso));
   smbt_spi_slave far (.sck(sck), .mosi(mosi), .miso(miso), .sel(sel), .mode(mode[1:0]),
      .lsb(cfg[0]), .got(got));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic summarize;
      if (fails == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic open_port(input smbt_row_t w);
      tick();
      mode = w.m;
      rate = w.r;
      cfg = {31'h0, w.fds[2]};
      drv = w.fds[1];
      res = w.fds[0];
      oreq = 1'b1;
      tick();
      oreq = 1'b0;
      chk("open_done", odone, 1);
      chk("open_status", ostat, w.st);
   endtask
   task automatic close_port;
      tick();
      creq = 1'b1;
      tick();
      creq = 1'b0;
      chk("closed", is_open, 0);
   endtask
   // one transfer; the receive side may stall to fill the buffer
   task automatic xfer(input logic [1:0] k, input int n, input int stall, input logic ckrx);
      int i, j, c;
      logic fin;
      i = 0;
      j = 0;
      c = 0;
      fin = 1'b0;
      tick();
      sel = 1'b1;
      kind = k;
      tcnt = n[15:0];
      rcnt = n[15:0];
      tvalid = k != `SMBT_KIND_READ && n > 0;
      tdata = tx[0];
      rx_rdy = stall == 0;
      start = 1'b1;
      tick();
      start = 1'b0;
      while (c < 9000 && !(fin && (k == `SMBT_KIND_WRITE || j == n)))
      begin
         @(negedge clk);
         fin = fin || xdone === 1'b1;
         if (tvalid && tready === 1'b1)
            i++;
         if (rx_rdy && rvalid === 1'b1)
         begin
            if (ckrx)
               chk("rx_byte", rdata, exp_rep + j[7:0]);
            j++;
         end
         if (c == stall - 1)
            chk("fifo_full", rvalid & busy, 1);
         tick();
         tvalid = tvalid && i < n;
         tdata = tx[i % 10];
         rx_rdy = c >= stall;
         c++;
      end
      chk("done", fin, 1);
      chk("bytes", j, k == `SMBT_KIND_WRITE ? 0 : n);
      if (n > 0)
         chk("slave_got", got, k == `SMBT_KIND_READ ? `SMBT_FILLER : tx[n - 1]);
      exp_rep = exp_rep + n[7:0];
      sel = 1'b0;
   endtask
   initial
   begin
      for (int q = 0; q < 10; q++)
         tx[q] = 8'hC3 ^ (8'h15 * q[7:0]);
      repeat (4) @(posedge clk);
      #1 arst_n = 1'b1;
      // each good open runs a two byte exchange, then closes
      for (int q = 0; q < 11; q++)
      begin
         open_port(rows[q]);
         chk("is_open", is_open, rows[q].st == 16'h0);
         if (is_open === 1'b1)
         begin
            xfer(`SMBT_KIND_DUPLEX, 2, 0, 1'b1);
            close_port();
         end
      end
      // second open is refused and leaves the port open
      open_port(rows[0]);
      open_port(smbt_row_t'{32'h0, `SMBT_RATE_1M, 3'h3, `SMBT_ST_ALREADY_OPEN});
      chk("still_open", is_open, 1);
      xfer(`SMBT_KIND_WRITE, 3, 0, 1'b1);
      xfer(`SMBT_KIND_READ, 10, 3000, 1'b1);
      xfer(`SMBT_KIND_DUPLEX, 0, 0, 1'b1);
      close_port();
      close_port();
      chk("no_answer", odone, 0);
      // a start on a closed port is ignored
      start = 1'b1;
      tick();
      start = 1'b0;
      tick();
      chk("closed_idle", busy, 0);
      // reset in mid transfer closes the port and parks the pins
      open_port(rows[0]);
      sel = 1'b1;
      kind = `SMBT_KIND_READ;
      rcnt = 16'h0004;
      start = 1'b1;
      tick();
      start = 1'b0;
      repeat (40) tick();
      chk("mid_busy", busy, 1);
      arst_n = 1'b0;
      #1;
      chk("rst_sck", sck, 0);
      chk("rst_mosi", mosi, 1);
      chk("rst_open", is_open, 0);
      tick();
      arst_n = 1'b1;
      tick();
      chk("rst_busy", busy, 0);
      chk("rst_status", ostat, `SMBT_ST_OK);
      sel = 1'b0;
      summarize();
   end
   // cut a hang short well past the longest sequence
   initial
   begin
      repeat (40000) @(posedge clk);
      fails++;
      summarize();
   end
endmodule
`default_nettype wire
